/* verilog/pgw_glue.sv */
/*
 * pgw_glue: PCI-side glue of the serial-bus host controller: config
 * registers, 2 KB operational window decode, quadlet swap, parity and
 * bus-error funnel, DMA kill and expansion ROM autoload of the image.
 * Assumes: PCI protocol phases are decoded outside; requests arrive as
 * single-cycle strobes synchronous to clock_i.
 */
`timescale 1ns/1ps
module pgw_glue #(
    parameter bit          SWAP_EN    = 1'b1,
    parameter bit          VBAR_EN    = 1'b0,
    parameter int          VBAR_LSB   = 12,
    parameter int          ROM_AW     = 16,
    parameter logic [15:0] IMG_BASE   = 16'h0000,
    parameter logic [15:0] IMG_WORDS  = 16'h0100
) (
    input  wire logic                      clock_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      ce_i,
    input  wire logic                      cfg_req_i,
    input  wire logic                      cfg_we_i,
    input  wire logic [7:0]                cfg_ofs_i,
    input  wire logic [3:0]                cfg_be_i,
    input  wire logic [31:0]               cfg_wdata_i,
    output logic                           cfg_ack_o,
    output logic      [31:0]               cfg_rdata_o,
    input  wire logic                      tgt_req_i,
    input  wire logic                      tgt_we_i,
    input  wire logic [31:0]               tgt_addr_i,
    input  wire logic [3:0]                tgt_be_i,
    input  wire logic [31:0]               tgt_wdata_i,
    input  wire logic                      tgt_par_i,
    output logic                           tgt_ack_o,
    output logic                           tgt_miss_o,
    output logic      [31:0]               tgt_rdata_o,
    output logic                           reg_wr_o,
    output logic                           reg_rd_o,
    output logic      [pgw_pkg::WIN_AW-1:0] reg_addr_o,
    output logic      [3:0]                reg_be_o,
    output logic      [31:0]               reg_wdata_o,
    input  wire logic                      reg_rvalid_i,
    input  wire logic [31:0]               reg_rdata_i,
    input  wire logic [31:0]               dma_wdata_i,
    output logic      [31:0]               dma_wdata_o,
    input  wire logic                      dma_rvalid_i,
    input  wire logic [31:0]               dma_rdata_i,
    input  wire logic [3:0]                dma_rbe_i,
    input  wire logic                      dma_rpar_i,
    input  wire logic [pgw_pkg::CTX_W-1:0] dma_rctx_i,
    input  wire logic                      dma_abort_i,
    input  wire logic [pgw_pkg::CTX_W-1:0] dma_actx_i,
    output logic                           op_rvalid_o,
    output logic      [31:0]               op_rdata_o,
    output logic                           perr_n_o,
    output logic                           err_o,
    output logic      [pgw_pkg::CTX_W-1:0] err_ctx_o,
    output logic                           dma_kill_o,
    output logic                           bus_master_enable_o,
    output logic                           rom_rd_o,
    output logic      [ROM_AW-1:0]         rom_addr_o,
    input  wire logic                      rom_valid_i,
    input  wire logic [31:0]               rom_data_i,
    output logic                           load_valid_o,
    output logic      [15:0]               load_addr_o,
    output logic      [31:0]               load_data_o,
    output logic                           load_done_o
);
    logic [pgw_pkg::CMD_W-1:0]     cmd_ff;
    logic [pgw_pkg::BAR_PTR_W-1:0] bar_ptr_ff;
    logic [31:VBAR_LSB]            vbar_ff;
    logic                          swap_ff;
    logic                          rd_pend_ff;
    logic                          tpar_pend_ff;
    logic                          mast_q_ff;
    logic                          rom_busy_ff;
    logic [15:0]                   ld_cnt_ff;
    pgw_pkg::pgw_ld_state_t        ld_st_ff;
    pgw_pkg::pgw_ld_state_t        nxt_ld_st;
    logic [31:0]                   bemask;
    logic [31:0]                   bar_rd;
    logic [31:0]                   vbar_rd;
    logic [31:0]                   cfg_rd;
    logic                          win_hit;
    logic                          tpar_bad;
    logic                          dpar_bad;
    logic [31:0]                   sw_tgt_w;
    logic [31:0]                   sw_reg_r;
    logic [31:0]                   sw_dma_w;
    logic [31:0]                   sw_dma_r;
    logic                          swap_on;

    assign swap_on = swap_ff & SWAP_EN;
    assign bemask  = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}},
                      {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};

    // constant fields are wired, not stored, so no write can reach them
    assign bar_rd = {bar_ptr_ff, 8'h00, 1'b0,
                     pgw_pkg::BAR_TYPE_32, 1'b0};
    assign vbar_rd = VBAR_EN ? {vbar_ff, {VBAR_LSB{1'b0}}} : 32'h00000000;

    always_comb begin
        unique case (cfg_ofs_i)
            pgw_pkg::CFG_CMD_OFS:  cfg_rd = {24'h000000, cmd_ff};
            pgw_pkg::CFG_BAR0_OFS: cfg_rd = bar_rd;
            pgw_pkg::CFG_BAR1_OFS: cfg_rd = vbar_rd;
            pgw_pkg::CFG_SWAP_OFS: cfg_rd = {31'h00000000, swap_on};
            default:               cfg_rd = 32'h00000000;
        endcase
    end

    // config reads bypass the swappers entirely
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_ack_o   <= 1'b0;
            cfg_rdata_o <= 32'h00000000;
        end else if (ce_i) begin
            cfg_ack_o <= cfg_req_i;
            if (cfg_req_i && !cfg_we_i) begin
                cfg_rdata_o <= cfg_rd;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_ff     <= pgw_pkg::CMD_RST;
            bar_ptr_ff <= pgw_pkg::BAR_PTR_RST;
            vbar_ff    <= '0;
            swap_ff    <= pgw_pkg::SWAP_RST;
        end else if (ce_i && cfg_req_i && cfg_we_i) begin
            unique case (cfg_ofs_i)
                pgw_pkg::CFG_CMD_OFS: begin
                    cmd_ff <= (cmd_ff & ~bemask[7:0]) | (cfg_wdata_i[7:0] & bemask[7:0]);
                end
                pgw_pkg::CFG_BAR0_OFS: begin
                    bar_ptr_ff <= (bar_ptr_ff & ~bemask[31:12])
                                | (cfg_wdata_i[31:12] & bemask[31:12]);
                end
                pgw_pkg::CFG_BAR1_OFS: begin
                    vbar_ff <= (vbar_ff & ~bemask[31:VBAR_LSB])
                             | (cfg_wdata_i[31:VBAR_LSB] & bemask[31:VBAR_LSB]);
                end
                pgw_pkg::CFG_SWAP_OFS: begin
                    if (cfg_be_i[0]) begin
                        swap_ff <= cfg_wdata_i[pgw_pkg::SWAP_BIT] & SWAP_EN;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // window decode: bit 11 must be zero, upper half of the 4 KB slot is dead
    assign win_hit = cmd_ff[pgw_pkg::CMD_MEM_BIT]
                   && tgt_addr_i[31:12] == bar_ptr_ff
                   && !tgt_addr_i[pgw_pkg::WIN_AW];

    pgw_quad_swap #(.W(32)) u_sw_tgt_w (
        .en_i   (swap_on),
        .data_i (tgt_wdata_i),
        .data_o (sw_tgt_w)
    );
    pgw_quad_swap #(.W(32)) u_sw_reg_r (
        .en_i   (swap_on),
        .data_i (reg_rdata_i),
        .data_o (sw_reg_r)
    );
    pgw_quad_swap #(.W(32)) u_sw_dma_w (
        .en_i   (swap_on),
        .data_i (dma_wdata_i),
        .data_o (sw_dma_w)
    );
    pgw_quad_swap #(.W(32)) u_sw_dma_r (
        .en_i   (swap_on),
        .data_i (dma_rdata_i),
        .data_o (sw_dma_r)
    );

    // one target access at a time; requests during a read are dropped
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_pend_ff  <= 1'b0;
            tgt_ack_o   <= 1'b0;
            tgt_miss_o  <= 1'b0;
            tgt_rdata_o <= 32'h00000000;
            reg_wr_o    <= 1'b0;
            reg_rd_o    <= 1'b0;
            reg_addr_o  <= '0;
            reg_be_o    <= 4'h0;
            reg_wdata_o <= 32'h00000000;
        end else if (ce_i) begin
            reg_wr_o   <= 1'b0;
            reg_rd_o   <= 1'b0;
            tgt_ack_o  <= 1'b0;
            tgt_miss_o <= 1'b0;
            if (rd_pend_ff) begin
                if (reg_rvalid_i) begin
                    rd_pend_ff  <= 1'b0;
                    tgt_ack_o   <= 1'b1;
                    tgt_rdata_o <= sw_reg_r;
                end
            end else if (tgt_req_i) begin
                if (win_hit) begin
                    reg_addr_o  <= tgt_addr_i[pgw_pkg::WIN_AW-1:0];
                    reg_be_o    <= swap_on ? {tgt_be_i[0], tgt_be_i[1],
                                              tgt_be_i[2], tgt_be_i[3]} : tgt_be_i;
                    reg_wdata_o <= sw_tgt_w;
                    reg_wr_o    <= tgt_we_i;
                    reg_rd_o    <= !tgt_we_i;
                    rd_pend_ff  <= !tgt_we_i;
                    tgt_ack_o   <= tgt_we_i;
                end else begin
                    tgt_miss_o <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dma_wdata_o <= 32'h00000000;
            op_rvalid_o <= 1'b0;
            op_rdata_o  <= 32'h00000000;
        end else if (ce_i) begin
            dma_wdata_o <= sw_dma_w;
            op_rvalid_o <= dma_rvalid_i;
            if (dma_rvalid_i) begin
                op_rdata_o <= sw_dma_r;
            end
        end
    end

    // even parity over data, byte enables and par
    assign tpar_bad = tgt_req_i && !rd_pend_ff && win_hit && tgt_we_i
                    && ^{tgt_wdata_i, tgt_be_i, tgt_par_i};
    assign dpar_bad = dma_rvalid_i && ^{dma_rdata_i, dma_rbe_i, dma_rpar_i};

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            perr_n_o <= 1'b1;
        end else if (ce_i) begin
            perr_n_o <= !((tpar_bad || dpar_bad)
                        && cmd_ff[pgw_pkg::CMD_PER_BIT]);
        end
    end

    // master errors win the cycle; a target parity error waits until a cycle with no master error
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            err_o        <= 1'b0;
            err_ctx_o    <= '0;
            tpar_pend_ff <= 1'b0;
        end else if (ce_i) begin
            if (dma_abort_i) begin
                err_o     <= 1'b1;
                err_ctx_o <= dma_actx_i;
            end else if (dpar_bad) begin
                err_o     <= 1'b1;
                err_ctx_o <= dma_rctx_i;
            end else if (tpar_pend_ff || tpar_bad) begin
                err_o     <= 1'b1;
                err_ctx_o <= pgw_pkg::CTX_TARGET;
            end else begin
                err_o <= 1'b0;
            end
            if (tpar_bad) begin
                tpar_pend_ff <= dma_abort_i || dpar_bad || tpar_pend_ff;
            end else if (!dma_abort_i && !dpar_bad) begin
                tpar_pend_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mast_q_ff           <= 1'b0;
            bus_master_enable_o <= 1'b0;
            dma_kill_o          <= 1'b0;
        end else if (ce_i) begin
            mast_q_ff           <= cmd_ff[pgw_pkg::CMD_MAST_BIT];
            bus_master_enable_o <= cmd_ff[pgw_pkg::CMD_MAST_BIT];
            dma_kill_o          <= mast_q_ff && !cmd_ff[pgw_pkg::CMD_MAST_BIT];
        end
    end

    // autoload: read-only ROM port, no software path to start or steer it
    always_comb begin
        nxt_ld_st = ld_st_ff;
        unique case (ld_st_ff)
            pgw_pkg::PGW_LD_IDLE:  nxt_ld_st = pgw_pkg::PGW_LD_FETCH;
            pgw_pkg::PGW_LD_FETCH: nxt_ld_st = pgw_pkg::PGW_LD_WAIT;
            pgw_pkg::PGW_LD_WAIT: begin
                if (rom_valid_i) begin
                    nxt_ld_st = (ld_cnt_ff == IMG_WORDS - 16'h0001)
                              ? pgw_pkg::PGW_LD_DONE : pgw_pkg::PGW_LD_FETCH;
                end
            end
            pgw_pkg::PGW_LD_DONE:  nxt_ld_st = pgw_pkg::PGW_LD_DONE;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ld_st_ff     <= pgw_pkg::PGW_LD_IDLE;
            ld_cnt_ff    <= 16'h0000;
            rom_busy_ff  <= 1'b0;
            rom_rd_o     <= 1'b0;
            rom_addr_o   <= '0;
            load_valid_o <= 1'b0;
            load_addr_o  <= 16'h0000;
            load_data_o  <= 32'h00000000;
            load_done_o  <= 1'b0;
        end else if (ce_i) begin
            ld_st_ff     <= nxt_ld_st;
            rom_rd_o     <= 1'b0;
            load_valid_o <= 1'b0;
            if (ld_st_ff == pgw_pkg::PGW_LD_FETCH) begin
                rom_rd_o    <= 1'b1;
                rom_busy_ff <= 1'b1;
                rom_addr_o  <= ROM_AW'(IMG_BASE + ld_cnt_ff);
            end
            if (ld_st_ff == pgw_pkg::PGW_LD_WAIT && rom_valid_i) begin
                rom_busy_ff  <= 1'b0;
                load_valid_o <= 1'b1;
                load_addr_o  <= ld_cnt_ff;
                load_data_o  <= rom_data_i;
                ld_cnt_ff    <= ld_cnt_ff + 16'h0001;
            end
            load_done_o <= (nxt_ld_st == pgw_pkg::PGW_LD_DONE);
        end
    end

    a_bar_const_bits: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        cfg_ack_o && $past(cfg_ofs_i) == pgw_pkg::CFG_BAR0_OFS && !$past(cfg_we_i)
        && $past(ce_i) |-> cfg_rdata_o[11:0] == 12'h000)
        else $error("window base low bits not zero");

    a_swap_reserved: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        cfg_ack_o && $past(cfg_ofs_i) == pgw_pkg::CFG_SWAP_OFS && !$past(cfg_we_i)
        && $past(ce_i) |-> cfg_rdata_o[31:1] == 31'h00000000)
        else $error("swap reserved bits not zero");

    a_win_decode: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ce_i && tgt_req_i && !rd_pend_ff && tgt_addr_i[pgw_pkg::WIN_AW]
        |=> !reg_wr_o && !reg_rd_o && tgt_miss_o)
        else $error("access above 2 KB reached registers");

    a_tgt_swap: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ce_i && tgt_req_i && !rd_pend_ff && win_hit && tgt_we_i && swap_on
        |=> reg_wr_o && reg_wdata_o[7:0] == $past(tgt_wdata_i[31:24]))
        else $error("write quadlet not byte swapped");

    a_perr_drive: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ce_i && dpar_bad && cmd_ff[pgw_pkg::CMD_PER_BIT] |=> !perr_n_o)
        else $error("bad parity did not drive perr");

    a_perr_quiet: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ce_i && !cmd_ff[pgw_pkg::CMD_PER_BIT] |=> perr_n_o)
        else $error("perr driven with response disabled");

    a_err_ctx: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ce_i && dma_abort_i |=> err_o && err_ctx_o == $past(dma_actx_i))
        else $error("abort not reported with its context");

    a_err_pending: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ce_i && tpar_bad && dma_abort_i ##1 ce_i && !dma_abort_i && !dpar_bad
        |=> err_o && err_ctx_o == pgw_pkg::CTX_TARGET)
        else $error("target parity error lost");

    a_dma_kill: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ce_i && $fell(cmd_ff[pgw_pkg::CMD_MAST_BIT]) |=> dma_kill_o)
        else $error("bus master drop did not kill dma");

    a_rom_ack: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ce_i && ld_st_ff == pgw_pkg::PGW_LD_WAIT && rom_valid_i
        |=> load_valid_o && load_data_o == $past(rom_data_i))
        else $error("rom word not delivered unswapped");
endmodule // pgw_glue

/* common/pgw_pkg.sv */
/*
 * pgw_pkg: constants for the PCI register-window glue (config offsets,
 * field positions, reset values, widths).
 * Assumes: config offsets are byte addresses of dword-aligned registers.
 */
package pgw_pkg;
    // config space byte offsets
    localparam logic [7:0]  CFG_CMD_OFS  = 8'h04;
    localparam logic [7:0]  CFG_BAR0_OFS = 8'h10;
    localparam logic [7:0]  CFG_BAR1_OFS = 8'h14;
    localparam logic [7:0]  CFG_SWAP_OFS = 8'h40;
    // command register fields
    localparam int          CMD_W        = 8;
    localparam int          CMD_MEM_BIT  = 1;
    localparam int          CMD_MAST_BIT = 2;
    localparam int          CMD_PER_BIT  = 6;
    localparam logic [7:0]  CMD_RST      = 8'h00;
    // window base register fields
    localparam int          BAR_IND_BIT  = 0;
    localparam int          BAR_TYPE_LSB = 1;
    localparam int          BAR_PF_BIT   = 3;
    localparam int          BAR_PTR_LSB  = 12;
    localparam int          BAR_PTR_W    = 20;
    localparam logic [1:0]  BAR_TYPE_32  = 2'h0;
    localparam logic [19:0] BAR_PTR_RST  = 20'h00000;
    // operational window: 2 KB inside a 4 KB slot
    localparam int          WIN_AW       = 11;
    // swap control register
    localparam int          SWAP_BIT     = 0;
    localparam logic        SWAP_RST     = 1'b0;
    // error tagging
    localparam int          CTX_W        = 5;
    localparam logic [4:0]  CTX_TARGET   = 5'h1f;
    // autoload states
    typedef enum logic [1:0] {
        PGW_LD_IDLE,
        PGW_LD_FETCH,
        PGW_LD_WAIT,
        PGW_LD_DONE
    } pgw_ld_state_t;
endpackage

/* verilog/pgw_quad_swap.sv */
/*
 * pgw_quad_swap: reverses byte order of a quadlet when enabled.
 * Assumes: W is a multiple of 8; purely combinational, caller registers.
 */
`timescale 1ns/1ps
module pgw_quad_swap #(
    parameter int W = 32
) (
    input  wire logic         en_i,
    input  wire logic [W-1:0] data_i,
    output logic      [W-1:0] data_o
);
    logic [W-1:0] rev;

    always_comb begin
        for (int b = 0; b < W / 8; b++) begin
            rev[8*b +: 8] = data_i[W-8-8*b +: 8];
        end
    end

    assign data_o = en_i ? rev : data_i;
endmodule // pgw_quad_swap

/* bench/pgw_far_model.sv */
/*
 * pgw_far_model: operational register file and expansion ROM behind the glue.
 * Assumes: one clock; answers one cycle after each read strobe.
 */
`timescale 1ns/1ps
module pgw_far_model (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [10:0] reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic             reg_rvalid_o,
    output logic      [31:0] reg_rdata_o,
    input  wire logic        rom_rd_i,
    input  wire logic [15:0] rom_addr_i,
    output logic             rom_valid_o,
    output logic      [31:0] rom_data_o
);
    logic [31:0] mem_ff [4];
    always_ff @(posedge clock_i) begin
        if (reg_wr_i) begin
            mem_ff[reg_addr_i[3:2]] <= reg_wdata_i;
        end
    end
    // idle data lines toggle so a stale value never looks valid
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rvalid_o <= 1'b0;
            reg_rdata_o  <= 32'h0;
            rom_valid_o  <= 1'b0;
            rom_data_o   <= 32'h0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            reg_rdata_o  <= reg_rd_i ? mem_ff[reg_addr_i[3:2]] : ~reg_rdata_o;
            rom_valid_o  <= rom_rd_i;
            // rom has no write path: image fixed
            rom_data_o   <= rom_rd_i ? {16'ha500, rom_addr_i} : ~rom_data_o;
        end
    end
endmodule // pgw_far_model

/* bench/test_pgw_glue.sv */
/*
 * test_pgw_glue: directed bench for the PCI register-window glue.
 * Assumes: pgw_pkg, pgw_glue and pgw_far_model are compiled first.
 */
`timescale 1ns/1ps
module test_pgw_glue;
    logic        clock_i, rst_n_i, cfg_req, cfg_we, tgt_req, tgt_we, tgt_par;
    logic        dma_rv, dma_ab, wr, ms;
    logic [7:0]  cfg_ofs;
    logic [10:0] ad;
    logic [4:0]  dma_ctx, lctx;
    logic [31:0] cfg_wd, tgt_addr, tgt_wd, rd, wd, dma_rd, dma_wd;
    logic        cfg_ack, tgt_ack, tgt_miss, reg_wr, reg_rd, reg_rv, op_rv, perr_n, err;
    logic        kill, rom_rd, rom_v, ld_v, ld_done, bme, dpb;
    logic [3:0]  reg_be;
    logic [4:0]  err_ctx;
    logic [10:0] reg_addr;
    logic [15:0] rom_addr, ld_a;
    logic [31:0] cfg_rdata, tgt_rdata, reg_wdata, reg_rdata, dma_wo, op_rd, rom_d, ld_d;
    int          errors = 0, cmp_count = 0, cyc = 0, nload = 0, nerr = 0, nperr = 0;
    int          nkill = 0;
    localparam logic [31:0] BAR = 32'h12345000;
    localparam logic [3:0]  TBE = 4'h3;
    pgw_glue #(.IMG_WORDS(16'h0004)) pgw_glue_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
        .cfg_req_i(cfg_req), .cfg_we_i(cfg_we), .cfg_ofs_i(cfg_ofs), .cfg_be_i(4'hf),
        .cfg_wdata_i(cfg_wd), .cfg_ack_o(cfg_ack), .cfg_rdata_o(cfg_rdata),
        .tgt_req_i(tgt_req), .tgt_we_i(tgt_we), .tgt_addr_i(tgt_addr), .tgt_be_i(TBE),
        .tgt_wdata_i(tgt_wd), .tgt_par_i(tgt_par), .tgt_ack_o(tgt_ack),
        .tgt_miss_o(tgt_miss), .tgt_rdata_o(tgt_rdata), .reg_wr_o(reg_wr),
        .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_be_o(reg_be),
        .reg_wdata_o(reg_wdata), .reg_rvalid_i(reg_rv), .reg_rdata_i(reg_rdata),
        .dma_wdata_i(dma_wd), .dma_wdata_o(dma_wo), .dma_rvalid_i(dma_rv),
        .dma_rdata_i(dma_rd), .dma_rbe_i(4'hf), .dma_rpar_i(^{dma_rd, 4'hf} ^ dpb),
        .dma_rctx_i(dma_ctx), .dma_abort_i(dma_ab), .dma_actx_i(dma_ctx),
        .op_rvalid_o(op_rv), .op_rdata_o(op_rd), .perr_n_o(perr_n), .err_o(err),
        .err_ctx_o(err_ctx), .dma_kill_o(kill), .bus_master_enable_o(bme), .rom_rd_o(rom_rd),
        .rom_addr_o(rom_addr), .rom_valid_i(rom_v), .rom_data_i(rom_d),
        .load_valid_o(ld_v), .load_addr_o(ld_a), .load_data_o(ld_d), .load_done_o(ld_done));
    pgw_far_model pgw_far_model_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rvalid_o(reg_rv),
        .reg_rdata_o(reg_rdata), .rom_rd_i(rom_rd), .rom_addr_i(rom_addr),
        .rom_valid_o(rom_v), .rom_data_o(rom_d));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("ERROR %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic results();
        $display("counts: %0d compares, %0d mismatches", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cfg(input logic we, input logic [7:0] o, input logic [31:0] d);
        @(negedge clock_i);
        cfg_req = 1'b1;
        cfg_we = we;
        cfg_ofs = o;
        cfg_wd = d;
        @(posedge clock_i);
        #1;
        chk({31'h0, cfg_ack}, 32'h1);
        rd = cfg_rdata;
        @(negedge clock_i);
        cfg_req = 1'b0;
    endtask
    // reads block until answered, so the wait is bounded rather than fixed
    task automatic tgt(input logic we, input logic [31:0] a, d, input logic bad);
        int n;
        @(negedge clock_i);
        tgt_req = 1'b1;
        tgt_we = we;
        tgt_addr = a;
        tgt_wd = d;
        tgt_par = ^{d, TBE} ^ bad;
        @(posedge clock_i);
        #1;
        wr = reg_wr;
        wd = reg_wdata;
        ad = reg_addr;
        ms = tgt_miss;
        @(negedge clock_i);
        tgt_req = 1'b0;
        n = 0;
        while (tgt_ack !== 1'b1 && tgt_miss !== 1'b1 && n < 20) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        rd = tgt_rdata;
    endtask
    always @(negedge clock_i) begin
        cyc++;
        if (ld_v === 1'b1) begin
            chk({16'h0, ld_a}, nload);
            nload++;
            chk(ld_d, {16'ha500, ld_a});
        end
        if (err === 1'b1) begin
            nerr++;
            lctx = err_ctx;
        end
        if (perr_n === 1'b0) nperr++;
        if (kill === 1'b1) nkill++;
        if (cyc == 3000) begin
            errors++;
            results();
        end
    end
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    initial begin
        {rst_n_i, cfg_req, cfg_we, tgt_req, tgt_we, tgt_par, dma_rv, dma_ab, dpb} = '0;
        {cfg_ofs, dma_ctx, cfg_wd, tgt_addr, tgt_wd, dma_rd} = '0;
        dma_wd = 32'haabbccdd;
        repeat (12) @(posedge clock_i);
        @(negedge clock_i);
        rst_n_i = 1'b1;
        cfg(0, pgw_pkg::CFG_BAR0_OFS, 0);
        chk(rd, 32'h0);
        cfg(0, pgw_pkg::CFG_SWAP_OFS, 0);
        chk(rd, 32'h0);
        cfg(0, pgw_pkg::CFG_BAR1_OFS, 0);
        chk(rd, 32'h0);
        // four words at three cycles each outlast the three reads above
        repeat (10) @(negedge clock_i);
        chk(32'(nload), 32'h4);
        chk({31'h0, ld_done}, 32'h1);
        $display("test reset and autoload done");
        cfg(1, pgw_pkg::CFG_BAR0_OFS, 32'hffffffff);
        cfg(0, pgw_pkg::CFG_BAR0_OFS, 0);
        chk(rd, 32'hfffff000);
        cfg(1, pgw_pkg::CFG_BAR0_OFS, 32'h12345fff);
        cfg(0, pgw_pkg::CFG_BAR0_OFS, 0);
        chk(rd, BAR);
        $display("test window base done");
        cfg(1, pgw_pkg::CFG_CMD_OFS, 32'h46);
        tgt(1, BAR | 32'h4, 32'h11223344, 0);
        chk({wr, ad, wd[19:0]}, {1'b1, 11'h004, 20'h23344});
        chk({28'h0, reg_be}, {28'h0, TBE});
        tgt(1, BAR | 32'h804, 32'h0, 0);
        chk({31'h0, ms}, 32'h1);
        cfg(1, pgw_pkg::CFG_SWAP_OFS, 32'h1);
        cfg(0, pgw_pkg::CFG_SWAP_OFS, 0);
        chk(rd, 32'h1);
        tgt(1, BAR | 32'h4, 32'h11223344, 0);
        chk(wd, 32'h44332211);
        chk({28'h0, reg_be}, {28'h0, TBE[0], TBE[1], TBE[2], TBE[3]});
        tgt(0, BAR | 32'h4, 32'h0, 0);
        chk(rd, 32'h11223344);
        cfg(0, pgw_pkg::CFG_BAR0_OFS, 0);
        chk(rd, BAR);
        chk(dma_wo, 32'hddccbbaa);
        chk({31'h0, bme}, 32'h1);
        @(negedge clock_i);
        {dma_rv, dma_rd, dma_ctx} = {1'b1, 32'h01020304, 5'h2};
        @(posedge clock_i);
        #1;
        chk({op_rv, op_rd[30:0]}, {1'b1, 31'h04030201});
        @(negedge clock_i);
        {dma_rv, dma_ab, dma_ctx} = {1'b0, 1'b1, 5'h3};
        @(posedge clock_i);
        #1;
        chk({err, err_ctx}, {1'b1, 5'h3});
        @(negedge clock_i);
        dma_ab = 1'b0;
        @(posedge clock_i);
        #1;
        chk({31'h0, err}, 32'h0);
        @(negedge clock_i);
        {dma_rv, dpb, dma_ctx} = {2'b11, 5'h4};
        @(posedge clock_i);
        #1;
        chk({err, err_ctx, perr_n}, {1'b1, 5'h4, 1'b0});
        @(negedge clock_i);
        {dma_rv, dpb} = 2'b00;
        $display("test swap and abort done");
        // abort lands on the same edge as a bad write: target error must follow
        fork
            tgt(1, BAR | 32'h8, 32'h5a5a0001, 1);
            begin
                @(negedge clock_i);
                dma_ab = 1'b1;
                @(negedge clock_i);
                dma_ab = 1'b0;
            end
        join
        repeat (3) @(posedge clock_i);
        chk(32'(nperr), 32'h2);
        chk({nerr[3:0], lctx}, {4'h4, pgw_pkg::CTX_TARGET});
        cfg(1, pgw_pkg::CFG_CMD_OFS, 32'h06);
        tgt(1, BAR | 32'h8, 32'h5a5a0001, 1);
        repeat (3) @(posedge clock_i);
        chk(32'(nperr), 32'h2);
        $display("test parity done");
        cfg(1, pgw_pkg::CFG_CMD_OFS, 32'h02);
        @(posedge clock_i);
        #1;
        chk({31'h0, kill}, 32'h1);
        @(posedge clock_i);
        #1;
        chk(32'(nkill), 32'h1);
        chk({31'h0, bme}, 32'h0);
        $display("test dma kill done");
        results();
    end
endmodule // test_pgw_glue
